// [hw/scr_judge.sv]
// Verdict judge: watches the observations of one test and decides pass or
// fail when the test reports done.
// Assumes observations come from on-chip logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module scr_judge (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  rst_n,
   // Sequencer side
   scr_obs_if.judge   obs
);
   import scr_pkg::*;

   logic [7:0] acc_q, acc_d;
   logic [7:0] idx_q;
   logic       bad_q, bad_d;
   logic       busy_q;
   logic       vld_q;
   logic       pass_q;

   wire        take     = obs.obs_valid & busy_q;
   wire        finish   = obs.obs_done & busy_q;
   wire [7:0]  d        = obs.obs_data;
   wire [7:0]  mid_dist = (d > `SCR_ADC_MID) ? d - `SCR_ADC_MID
                                            : `SCR_ADC_MID - d;
   wire        adc_bad  = (idx_q == 8'h00) ? (d > `SCR_ADC_LOW + `SCR_ADC_TOL)
                        : (idx_q == 8'h01) ? (d < `SCR_ADC_HIGH - `SCR_ADC_TOL)
                        : (idx_q == 8'h02) ? (mid_dist > `SCR_ADC_TOL)
                        : 1'b1;

   // Per-observation accumulation and mismatch detection.
   always_comb begin
      acc_d = acc_q;
      bad_d = bad_q;
      unique case (obs.test)
         T_PORT_A, T_PORT_B, T_PLM: bad_d = bad_q | (d != obs.expect_val); // see [RL8] [RL15]
         T_RAM:   bad_d = bad_q | (d != idx_q);                           // see [RL9]
         T_ROM:   acc_d = acc_q ^ d;                                      // see [RL10]
         T_ADC:   bad_d = bad_q | adc_bad;                                // see [RL13]
         default: acc_d = acc_q | d;
      endcase
   end

   // Final judgement at done: each test's closing condition.
   logic ok;
   always_comb begin
      unique case (obs.test)
         T_RAM:   ok = idx_q != 8'h00;
         T_ROM:   ok = ^acc_q;                                            // see [RL10]
         T_TIMER: ok = (acc_q & `SCR_MASK_TIMER) == `SCR_MASK_TIMER;      // see [RL11]
         T_SCI:   ok = (acc_q & `SCR_MASK_SCI) == `SCR_MASK_SCI;          // see [RL12]
         T_ADC:   ok = idx_q == `SCR_ADC_CONVS;                           // see [RL13]
         T_INT:   ok = (acc_q & `SCR_MASK_INT) == `SCR_MASK_INT;          // see [RL14]
         T_WDOG:  ok = (acc_q & `SCR_MASK_WDOG) == `SCR_MASK_WDOG;        // see [RL15]
         default: ok = 1'b1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q  <= 8'h00;
         idx_q  <= 8'h00;
         bad_q  <= 1'b0;
         busy_q <= 1'b0;
         vld_q  <= 1'b0;
         pass_q <= 1'b0;
      end else if (obs.start) begin
         acc_q  <= 8'h00;
         idx_q  <= 8'h00;
         bad_q  <= 1'b0;
         busy_q <= 1'b1;
         vld_q  <= 1'b0;
      end else begin
         vld_q <= finish;
         if (finish) begin
            busy_q <= 1'b0;
            pass_q <= ok & ~bad_q;
         end else if (take) begin
            acc_q <= acc_d;
            bad_q <= bad_d;
            idx_q <= idx_q + 8'h01;
         end
      end
   end

   assign obs.verdict_valid = vld_q;
   assign obs.verdict_pass  = pass_q;
endmodule

`default_nettype wire

// [hw/scr_obs_if.sv]
// Interface between the sequencer and the verdict judge.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface scr_obs_if;
   import scr_pkg::*;
   logic            start;
   scr_test_t       test;
   logic [7:0]      expect_val;
   logic            obs_valid;
   logic [7:0]      obs_data;
   logic            obs_done;
   logic            verdict_valid;
   logic            verdict_pass;

   modport seq (output start, test, expect_val, obs_valid, obs_data,
                obs_done, input verdict_valid, verdict_pass);
   modport judge (input start, test, expect_val, obs_valid, obs_data,
                  obs_done, output verdict_valid, verdict_pass);
endinterface

`default_nettype wire

// [hw/scr_pkg.sv]
// Types of the self-check result reporter: test order, sequencer states
// and the mapping from test to its failure code.
// Assumes scr_regs.svh on the include path.
`include "scr_regs.svh"

package scr_pkg;

   typedef enum logic [3:0] {
      T_PORT_A,
      T_PORT_B,
      T_RAM,
      T_ROM,
      T_TIMER,
      T_SCI,
      T_ADC,
      T_PLM,
      T_INT,
      T_WDOG
   } scr_test_t;

   typedef enum logic [2:0] {
      S_CAPTURE,
      S_IDLE,
      S_START,
      S_WAIT,
      S_FAIL
   } scr_state_t;

   function automatic logic [3:0] scr_fail_code(input scr_test_t t);
      unique case (t)
         T_PORT_A: scr_fail_code = `SCR_CODE_PORT_A;
         T_PORT_B: scr_fail_code = `SCR_CODE_PORT_B;
         T_RAM:    scr_fail_code = `SCR_CODE_RAM;
         T_ROM:    scr_fail_code = `SCR_CODE_ROM;
         T_TIMER:  scr_fail_code = `SCR_CODE_TIMER;
         T_SCI:    scr_fail_code = `SCR_CODE_SCI;
         T_ADC:    scr_fail_code = `SCR_CODE_ADC;
         T_PLM:    scr_fail_code = `SCR_CODE_PLM;
         T_INT:    scr_fail_code = `SCR_CODE_INT;
         T_WDOG:   scr_fail_code = `SCR_CODE_WDOG;
         default:  scr_fail_code = `SCR_LEDS_OFF;
      endcase
   endfunction

endpackage

// [hw/scr_regs.svh]
// Constants of the self-check result reporter: result codes, test patterns,
// acceptance masks and timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH

// Result codes on result pins 3..0, low level lights an indicator.
`define SCR_CODE_PORT_A   4'h9
`define SCR_CODE_PORT_B   4'h6
`define SCR_CODE_RAM      4'hA
`define SCR_CODE_ROM      4'hB
`define SCR_CODE_TIMER    4'hC
`define SCR_CODE_SCI      4'hD
`define SCR_CODE_ADC      4'hE
`define SCR_CODE_PLM      4'h1
`define SCR_CODE_INT      4'h2
`define SCR_CODE_WDOG     4'h3
`define SCR_LEDS_OFF      4'hF
`define SCR_LEDS_FLASH    4'h0

// Patterns driven to the ports and modulators under test.
`define SCR_PAT_PORT_A    8'h55
`define SCR_PAT_PORT_B    8'hAA
`define SCR_PAT_PLM       8'h80
`define SCR_PAT_NONE      8'h00

// Flags that each event-style test must see set.
`define SCR_MASK_TIMER    8'h1F
`define SCR_MASK_SCI      8'h0F
`define SCR_MASK_INT      8'h07
`define SCR_MASK_WDOG     8'h01

// Converter expectations: low reference, high reference, midpoint.
`define SCR_ADC_LOW       8'h00
`define SCR_ADC_HIGH      8'hFF
`define SCR_ADC_MID       8'h80
`define SCR_ADC_TOL       8'h04
`define SCR_ADC_CONVS     8'h03

// Cycles that a test may take before it counts as failed.
`define SCR_TIMEOUT       12'hFFF
// Cycles from reset release until the synchronised mode pins are valid.
`define SCR_SYNC_WAIT     2'h2

`endif

// [hw/scr_top.sv]
// Self-check sequencer and result reporter: repeats the test series until a test fails
// and shows the outcome on four active-low indicator pins.
// Assumes the test units answer on the observation port on this clock and
// that the mode pins are asynchronous to it.
//
// Contract
// [RL1] Fixture holds interrupt pin elevated and first capture input high, then resets.
// [RL2] Fixture holds mode select bit low to choose self-check over loaders.
// [RL3] After reset in self-check, tests run unaided and restart after completion.
// [RL4] Outcomes appear only on result pins 0 to 3.
// [RL5] Low level lights an indicator, high level darkens it.
// [RL6] All passing toggles the result pins; any failure holds a constant pattern.
// [RL7] Each failing test has its own fixed four-bit failure code.
// [RL8] Port test drives and checks the ports, mismatch gives a port code.
// [RL9] RAM test checks a counting pattern in every byte.
// [RL10] ROM test exclusive-ORs all bytes and expects odd-ones parity.
// [RL11] Timer test expects both capture, both compare and overflow flags set.
// [RL12] Serial test expects receive-full, transmit-empty, complete and framing flags.
// [RL13] Converter test checks low reference, high reference and their midpoint.
// [RL14] Interrupt test needs external, timer and serial interrupts to occur.
// [RL15] Modulator and watchdog are checked, each with its own failure code.
// [RL16] User software should not call the self-check routines.
// [RL17] First failing test stops the sequence and holds its code until reset.
`timescale 1ns/1ps
`default_nettype none
`include "scr_regs.svh"

module scr_top (
   // Clock and reset
   input  wire logic              MCLK_IN,
   input  wire logic              NRST_IN,
   // Mode pins, asynchronous
   input  wire logic              IRQ_HIGH_IN,
   input  wire logic              FIRST_CAPTURE_INPUT_IN,
   input  wire logic              MODE_SELECT_BIT_IN,
   // Observation port from the units under test
   input  wire logic              OBS_VALID_IN,
   input  wire logic [7:0]        OBS_DATA_IN,
   input  wire logic              OBS_DONE_IN,
   // Test control to the units under test
   output logic                   TEST_START_OUT,
   output scr_pkg::scr_test_t     TEST_SEL_OUT,
   output logic [7:0]             DRIVE_OUT,
   output logic                   SELF_CHECK_OUT,
   // Result pins
   output logic [3:0]             RESULT_PIN_OUT,
   output logic [3:0]             RESULT_OE_OUT
);
   import scr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Mode pin synchronisers.

   logic [2:0] pins_raw;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;

   assign pins_raw = {IRQ_HIGH_IN, FIRST_CAPTURE_INPUT_IN, MODE_SELECT_BIT_IN};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
            if (!NRST_IN) begin
               sync1_q[g] <= 1'b0;
               sync2_q[g] <= 1'b0;
            end else begin
               sync1_q[g] <= pins_raw[g];
               sync2_q[g] <= sync1_q[g];
            end
         end
      end
   endgenerate

   // Self-check needs both elevated levels and the select bit low.
   wire want_check = sync2_q[2] & sync2_q[1] & ~sync2_q[0];     // see [RL1] [RL2]

   ////////////////////////////////////////////////////////////////////////
   // Judge.

   scr_obs_if obs_bus ();

   assign obs_bus.obs_valid = OBS_VALID_IN;
   assign obs_bus.obs_data  = OBS_DATA_IN;
   assign obs_bus.obs_done  = OBS_DONE_IN;

   scr_judge u_judge (
      .clk   (MCLK_IN),
      .rst_n (NRST_IN),
      .obs   (obs_bus.judge)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer.

   scr_state_t  state_q, state_d;
   scr_test_t   test_q, test_d;
   logic [11:0] wait_q;
   logic [1:0]  cap_q;
   logic        start_q;
   logic [7:0]  drive_q;
   logic        check_q;
   logic [3:0]  result_q, result_d;
   logic [3:0]  oe_q;

   wire timed_out = (state_q == S_WAIT) && (wait_q == `SCR_TIMEOUT);
   wire verdict   = (state_q == S_WAIT) && obs_bus.verdict_valid;
   wire passed    = verdict & obs_bus.verdict_pass;
   wire failed    = (verdict & ~obs_bus.verdict_pass) | timed_out;
   wire last_test = test_q == T_WDOG;

   wire [7:0] drive_d = (test_d == T_PORT_A) ? `SCR_PAT_PORT_A     // see [RL8]
                      : (test_d == T_PORT_B) ? `SCR_PAT_PORT_B
                      : (test_d == T_PLM)    ? `SCR_PAT_PLM        // see [RL15]
                      : `SCR_PAT_NONE;

   assign obs_bus.start      = start_q;
   assign obs_bus.test       = test_q;
   assign obs_bus.expect_val = drive_q;

   always_comb begin
      state_d  = state_q;
      test_d   = test_q;
      result_d = result_q;
      unique case (state_q)
         S_CAPTURE: begin
            if (cap_q == `SCR_SYNC_WAIT) begin
               state_d = want_check ? S_START : S_IDLE;
            end
         end
         S_IDLE: begin
         end
         S_START: begin
            state_d = S_WAIT;
         end
         S_WAIT: begin
            if (failed) begin
               state_d  = S_FAIL;                                   // see [RL17]
               result_d = scr_fail_code(test_q);                    // see [RL7]
            end else if (passed) begin
               state_d = S_START;
               if (last_test) begin
                  test_d   = T_PORT_A;                              // see [RL3]
                  result_d = ~result_q;                             // see [RL6]
               end else begin
                  test_d = scr_test_t'(test_q + 4'h1);
               end
            end
         end
         S_FAIL: begin
         end
      endcase
   end

   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         state_q <= S_CAPTURE;
         test_q  <= T_PORT_A;
         cap_q   <= 2'h0;
      end else begin
         state_q <= state_d;
         test_q  <= test_d;
         if (state_q == S_CAPTURE) begin
            cap_q <= cap_q + 2'h1;
         end
      end
   end

   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         wait_q <= 12'h000;
      end else if (state_q == S_WAIT) begin
         wait_q <= wait_q + 12'h001;
      end else begin
         wait_q <= 12'h000;
      end
   end

   // Indicators start dark and are driven only in self-check mode.
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         start_q  <= 1'b0;
         drive_q  <= `SCR_PAT_NONE;
         check_q  <= 1'b0;
         result_q <= `SCR_LEDS_OFF;
         oe_q     <= 4'h0;
      end else begin
         start_q  <= state_d == S_START;
         drive_q  <= drive_d;
         check_q  <= (state_d != S_CAPTURE) && (state_d != S_IDLE);
         result_q <= result_d;                                      // see [RL5]
         oe_q     <= {4{(state_d != S_CAPTURE) && (state_d != S_IDLE)}}; // see [RL4]
      end
   end

   assign TEST_START_OUT = start_q;
   assign TEST_SEL_OUT   = test_q;
   assign DRIVE_OUT      = drive_q;
   assign SELF_CHECK_OUT = check_q;
   assign RESULT_PIN_OUT = result_q;
   assign RESULT_OE_OUT  = oe_q;
endmodule

`default_nettype wire

// [testbench/scr_checker.sv]
// Checker of the self-check result reporter, on the top module's ports.
// Assumes binding to scr_top on one clock domain.
`timescale 1ns/1ps
`default_nettype none

module scr_checker
   import scr_pkg::*;
(
   input wire logic       MCLK_IN,
   input wire logic       NRST_IN,
   input wire logic       OBS_VALID_IN,
   input wire logic       OBS_DONE_IN,
   input wire logic       TEST_START_OUT,
   input wire scr_test_t  TEST_SEL_OUT,
   input wire logic [7:0] DRIVE_OUT,
   input wire logic       SELF_CHECK_OUT,
   input wire logic [3:0] RESULT_PIN_OUT,
   input wire logic [3:0] RESULT_OE_OUT
);
   localparam logic [3:0] CODES [10] = '{4'h9, 4'h6, 4'hA, 4'hB, 4'hC,
                                          4'hD, 4'hE, 4'h1, 4'h2, 4'h3};
   logic [3:0] last_q;
   wire  [3:0] nxt_w  = (last_q == 4'h9) ? 4'h0 : last_q + 4'h1;
   wire  [3:0] code_w = CODES[TEST_SEL_OUT];
   wire  [7:0] pat_w  = (TEST_SEL_OUT == T_PORT_A) ? 8'h55 :
                        (TEST_SEL_OUT == T_PORT_B) ? 8'hAA :
                        (TEST_SEL_OUT == T_PLM)    ? 8'h80 : 8'h00;

   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!NRST_IN);

   ////////////////////////////////////////////////////////////////////////////
   // Remembers the test of the last start so the next one can be predicted.
   always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN)
         last_q <= 4'h9;
      else if (TEST_START_OUT)
         last_q <= TEST_SEL_OUT;
   end

   a_oe_mode: assert property (
      RESULT_OE_OUT == (SELF_CHECK_OUT ? 4'hF : 4'h0))
      else $error("result enables disagree with mode");
   a_start_pulse: assert property (
      TEST_START_OUT |=> !TEST_START_OUT)
      else $error("start pulse longer than one cycle");
   a_start_order: assert property (
      TEST_START_OUT |-> SELF_CHECK_OUT && TEST_SEL_OUT == nxt_w)
      else $error("test started out of order");
   a_done_answer: assert property (
      OBS_DONE_IN |-> ##[2:3] (TEST_START_OUT || $changed(RESULT_PIN_OUT)))
      else $error("no answer to test done");
   a_fail_hold: assert property (
      SELF_CHECK_OUT && !(RESULT_PIN_OUT inside {4'h0, 4'hF})
      |=> $stable(RESULT_PIN_OUT) && !TEST_START_OUT)
      else $error("failure code not held");
   a_fail_code: assert property (
      $changed(RESULT_PIN_OUT) && !(RESULT_PIN_OUT inside {4'h0, 4'hF})
      |-> RESULT_PIN_OUT == code_w)
      else $error("wrong failure code");
   a_flash_wrap: assert property (
      $changed(RESULT_PIN_OUT) && RESULT_PIN_OUT inside {4'h0, 4'hF}
      |-> ##[0:2] (TEST_START_OUT && TEST_SEL_OUT == T_PORT_A))
      else $error("pins toggled outside sequence wrap");
   a_drive_pat: assert property (
      OBS_VALID_IN |-> DRIVE_OUT == pat_w)
      else $error("wrong drive pattern");
endmodule

`default_nettype wire

// [testbench/scr_fixture_model.sv]
// Model of the units under test answering on the observation port.
// Assumes the bench picks which test to spoil and the pacing.
`timescale 1ns/1ps
`default_nettype none

module scr_fixture_model
   import scr_pkg::*;
(
   // Clock and test control from the device
   input  wire logic       clk_in,
   input  wire logic       start_in,
   input  wire scr_test_t  sel_in,
   input  wire logic [7:0] drive_in,
   // Scenario control from the bench
   input  wire logic [3:0] bad_in,
   input  wire logic [1:0] gap_in,
   input  wire logic [1:0] len_in,
   // Observation port to the device
   output logic            valid_out,
   output logic [7:0]      data_out,
   output logic            done_out
);
   int n;

   // The spoiling mask flips an odd number of bits, so parity breaks too.
   function automatic logic [7:0] obs(input scr_test_t t, input int i);
      logic [7:0] v;
      case (t)
         T_RAM:   v = 8'(i);
         T_ROM:   v = 8'h01;
         T_TIMER: v = 8'h1F;
         T_SCI:   v = 8'h0F;
         T_ADC:   v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'h80;
         T_INT:   v = 8'h07;
         T_WDOG:  v = 8'h01;
         default: v = drive_in;
      endcase
      return (bad_in == 4'(t)) ? v ^ 8'hC1 : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      valid_out = 1'b0;
      data_out  = 8'h00;
      done_out  = 1'b0;
      forever begin
         @(posedge clk_in);
         done_out <= 1'b0;
         if (!start_in) begin
            data_out <= ~data_out;
         end else begin
            n = (sel_in == T_ADC) ? 3 :
                (sel_in inside {T_PORT_A, T_PORT_B, T_RAM, T_PLM}) ?
                1 + len_in : 1;
            for (int i = 0; i < n; i++) begin
               valid_out <= 1'b1;
               data_out  <= obs(sel_in, i);
               @(posedge clk_in);
               if (gap_in != 2'h0) begin
                  valid_out <= 1'b0;
                  data_out  <= ~data_out;
                  repeat (gap_in) @(posedge clk_in);
               end
            end
            valid_out <= 1'b0;
            data_out  <= ~data_out;
            done_out  <= 1'b1;
         end
      end
   end
endmodule

`default_nettype wire

// [testbench/self_check_result_reporter_tb.sv]
// Self-checking bench of the self-check result reporter.
// Assumes scr_fixture_model answers the tests and scr_checker is bound.
`timescale 1ns/1ps
`default_nettype none

module self_check_result_reporter_tb;
   import scr_pkg::*;
   localparam logic [3:0] CODES [10] = '{4'h9, 4'h6, 4'hA, 4'hB, 4'hC,
                                          4'hD, 4'hE, 4'h1, 4'h2, 4'h3};
   logic       mclk, nrst, irq_high, cap_high, mode_bit, obs_valid, obs_done;
   logic       start, self_chk;
   logic [1:0] gap, len;
   logic [3:0] bad, pins, oe, last_pins;
   logic [7:0] obs_data, drive;
   scr_test_t  sel;
   logic [3:0] exp_q[$];
   logic [31:0] rnd = 32'hD0384D4E;
   int         n_errors = 0;
   int         cmp_count = 0;

   scr_top uut (.MCLK_IN(mclk), .NRST_IN(nrst), .IRQ_HIGH_IN(irq_high),
      .FIRST_CAPTURE_INPUT_IN(cap_high), .MODE_SELECT_BIT_IN(mode_bit),
      .OBS_VALID_IN(obs_valid), .OBS_DATA_IN(obs_data),
      .OBS_DONE_IN(obs_done), .TEST_START_OUT(start), .TEST_SEL_OUT(sel),
      .DRIVE_OUT(drive), .SELF_CHECK_OUT(self_chk),
      .RESULT_PIN_OUT(pins), .RESULT_OE_OUT(oe));
   scr_fixture_model partner (.clk_in(mclk), .start_in(start), .sel_in(sel),
      .drive_in(drive), .bad_in(bad), .gap_in(gap), .len_in(len),
      .valid_out(obs_valid), .data_out(obs_data), .done_out(obs_done));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [3:0] seen, input logic [3:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] r;
      r = s ^ (s << 13);
      r = r ^ (r >> 17);
      r = r ^ (r << 5);
      return r;
   endfunction

   // Fixture action: set mode pins, press reset for 16 cycles, release.
   // The fixture only works pins and reset, never the routines.
   task automatic restart(input logic irq, cap, md, input logic [3:0] b);
      @(posedge mclk);
      rnd = xorshift(rnd);
      nrst     <= 1'b0;
      irq_high <= irq;
      cap_high <= cap;
      mode_bit <= md;
      bad      <= b;
      gap      <= rnd[1:0];
      len      <= rnd[3:2];
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
   endtask

   task automatic drain;
      int k;
      for (k = 0; k < 20000 && exp_q.size() > 0; k++)
         @(posedge mclk);
      if (exp_q.size() > 0) begin
         n_errors++;
         $display("MISMATCH at %0t: expected result never shown", $time);
         finish_test();
      end
   endtask

   // Each change of the result pins takes the oldest expected value.
   always @(posedge mclk) begin
      if (!nrst)
         last_pins = 4'hF;
      else if (pins !== last_pins) begin
         last_pins = pins;
         check(pins, exp_q.size() > 0 ? exp_q.pop_front() : ~pins);
         check(oe, 4'hF);
      end
   end

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   initial begin
      nrst = 1'b0;
      irq_high = 1'b1;
      cap_high = 1'b1;
      mode_bit = 1'b0;
      bad = 4'hF;
      gap = 2'h0;
      len = 2'h0;
      // Each mode condition missing in turn: no self-check, pins undriven.
      for (int m = 0; m < 3; m++) begin
         restart(m != 0, m != 1, m == 2, 4'hF);
         repeat (64) @(posedge mclk);
         check(oe, 4'h0);
         check({3'h0, self_chk}, 4'h0);
         $display("Mode case %0d finished", m);
      end
      // Spoil each test in turn; its code must show and stay.
      for (int t = 0; t < 10; t++) begin
         restart(1'b1, 1'b1, 1'b0, 4'(t));
         exp_q.push_back(CODES[t]);
         drain();
         repeat (40) @(posedge mclk);
         check(pins, CODES[t]);
         $display("Failure case %0d finished", t);
      end
      // Good device: pins toggle once per completed sequence.
      restart(1'b1, 1'b1, 1'b0, 4'hF);
      exp_q.push_back(4'h0);
      exp_q.push_back(4'hF);
      exp_q.push_back(4'h0);
      drain();
      $display("Good device case finished");
      finish_test();
   end
endmodule

bind scr_top scr_checker chk (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN),
   .OBS_VALID_IN(OBS_VALID_IN), .OBS_DONE_IN(OBS_DONE_IN),
   .TEST_START_OUT(TEST_START_OUT), .TEST_SEL_OUT(TEST_SEL_OUT),
   .DRIVE_OUT(DRIVE_OUT), .SELF_CHECK_OUT(SELF_CHECK_OUT),
   .RESULT_PIN_OUT(RESULT_PIN_OUT), .RESULT_OE_OUT(RESULT_OE_OUT));

`default_nettype wire
